// ### hdl/ipv_irq_ctrl.sv
// Purpose: interrupt priority, masking and vector status
// Assumes: core pulses ack and return for one cycle
// Notes: traps take the lowest indices, users follow
//
// What this block does
// - the charge-time unit priority is a 3-bit field in bits 6:4, 7 highest, 0 off.
// - status bit 15 shows a request the core has not taken at its level.
// - with hold bit 13 set, the vector field shows the best pending request.
// - with hold clear, the vector field shows the last request taken.
// - status bits 11:8 read back the core level, 0 to 15.
// - bits 6:0 hold the vector field, vector number minus eight.
// - every user priority is 4 after reset.
// - a flag left set requests again once the handler returns.
// - return restores the level saved when the request was taken, up to STACK_DEPTH nested requests deep.
// - a trap flag left set re-enters the trap after its return.
// - the core level masks every request at or below it; a level written by software, 7 or below, never masks traps.
// - timed disable blocks levels 1 to 6 for its count, not level 7.
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
module ipv_irq_ctrl
    import ipv_pkg::*;
#(
    parameter int N_SRC = 8,
    parameter int N_TRAP = 4,
    parameter int STACK_DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire ipv_axil_req_t bus_req,
    output ipv_axil_rsp_t bus_rsp,
    input wire logic [N_SRC-1:0] src_event,
    input wire logic [N_TRAP-1:0] trap_event,
    input wire logic irq_ack,
    input wire logic irq_return,
    output logic irq_req,
    output logic [6:0] irq_vector_index,
    output logic [3:0] irq_level,
    output logic [3:0] cpu_level
);

    localparam int TOT = N_TRAP + N_SRC;
    localparam int SPW = $clog2(STACK_DEPTH + 1);
    localparam logic [31:0] PRIO_END = OFF_PRIO_BASE + 32'(4 * N_SRC);

    // ==========================================================
    // elaboration checks
    if (N_SRC < 1 || N_SRC > 16 || N_TRAP < 1 || N_TRAP > 8) begin : g_bad_count
        $error("bad source or trap count");
    end
    if (STACK_DEPTH < 1 || STACK_DEPTH > 16) begin : g_bad_depth
        $error("bad stack depth");
    end

    typedef struct packed {
        logic aw_held;
        logic [31:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [N_SRC-1:0][2:0] prio;
        logic [N_SRC-1:0] flags;
        logic [N_SRC-1:0] enables;
        logic [N_TRAP-1:0] traps;
        logic nest_dis;
        logic hold;
        logic [3:0] level;
        logic [STACK_DEPTH-1:0][3:0] stack;
        logic [SPW-1:0] sp;
        logic [15:0] dis_count;
        logic best_valid;
        logic [6:0] best_idx;
        logic [3:0] best_lvl;
        logic [6:0] acked_idx;
        logic unacked;
    } ipv_state_t;

    ipv_state_t st_reg;
    ipv_state_t st_next;

    logic [TOT-1:0] arb_req;
    logic [TOT-1:0][3:0] arb_levels;
    logic arb_valid;
    logic [6:0] arb_idx;
    logic [3:0] arb_lvl;
    logic take_ack;
    logic do_write;
    logic [15:0] wr_val;

    // ==========================================================
    // helpers
    function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
        logic [15:0] r;
        r = old_v;
        if (strb[0]) begin
            r[7:0] = new_v[7:0];
        end
        if (strb[1]) begin
            r[15:8] = new_v[15:8];
        end
        return r;
    endfunction

    // traps outrank users, the first trap highest
    function automatic logic [3:0] trap_level(input int k);
        return TRAP_TOP_LEVEL - 4'(k);
    endfunction

    function automatic logic prio_hit(input logic [31:0] a);
        return a >= OFF_PRIO_BASE && a < PRIO_END && a[1:0] == 2'h0;
    endfunction

    function automatic logic known_addr(input logic [31:0] a);
        return a == OFF_CTU_PRIO || a == OFF_CTRL_STAT || a == OFF_CTRL_ONE || a == OFF_FLAGS
            || a == OFF_ENABLES || a == OFF_STATUS_LOW || a == OFF_TIMED_DIS || prio_hit(a);
    endfunction

    // ==========================================================
    // request eligibility, traps first in index order
    always_comb begin
        arb_req = '0;
        arb_levels = '0;
        for (int k = 0; k < N_TRAP; k++) begin
            arb_req[k] = st_reg.traps[k];
            arb_levels[k] = trap_level(k);
        end
        for (int i = 0; i < N_SRC; i++) begin
            arb_levels[N_TRAP + i] = {1'b0, st_reg.prio[i]};
            arb_req[N_TRAP + i] = st_reg.flags[i] && st_reg.enables[i]
                && st_reg.prio[i] != PRIO_OFF
                && !(st_reg.dis_count != 16'h0000 && st_reg.prio[i] <= TIMED_MAX_PRIO);
        end
    end

    ipv_arbiter #(
        .TOT(TOT)
    ) u_arbiter (
        .req(arb_req),
        .levels(arb_levels),
        .valid(arb_valid),
        .index(arb_idx),
        .level(arb_lvl)
    );

    // ==========================================================
    // core request, only above the current level
    assign irq_req = st_reg.best_valid && st_reg.best_lvl > st_reg.level;
    assign take_ack = irq_ack && irq_req && !irq_return;
    assign irq_vector_index = st_reg.best_idx;
    assign irq_level = st_reg.best_lvl;
    assign cpu_level = st_reg.level;

    // ==========================================================
    // bus handshake outputs
    assign bus_rsp.awready = !st_reg.aw_held;
    assign bus_rsp.wready = !st_reg.w_held;
    assign bus_rsp.bvalid = st_reg.bvalid;
    assign bus_rsp.bresp = st_reg.bresp;
    assign bus_rsp.arready = !st_reg.rvalid;
    assign bus_rsp.rvalid = st_reg.rvalid;
    assign bus_rsp.rdata = st_reg.rdata;
    assign bus_rsp.rresp = st_reg.rresp;

    assign do_write = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;

    // ==========================================================
    // next state
    always_comb begin
        st_next = st_reg;
        wr_val = 16'h0000;

        // arbitration result is registered so the vector never glitches
        st_next.best_valid = arb_valid;
        st_next.best_idx = arb_idx;
        st_next.best_lvl = arb_lvl;
        st_next.unacked = arb_valid && arb_lvl <= st_reg.level;

        // timed disable counts clocks
        if (st_reg.dis_count != 16'h0000) begin
            st_next.dis_count = st_reg.dis_count - 16'h0001;
        end

        // return restores the saved level; an empty stack is left alone
        if (irq_return && st_reg.sp != '0) begin
            st_next.level = st_reg.stack[st_reg.sp - SPW'(1)];
            st_next.sp = st_reg.sp - SPW'(1);
        end else if (take_ack) begin
            if (st_reg.sp != SPW'(STACK_DEPTH)) begin
                st_next.stack[st_reg.sp] = st_reg.level;
                st_next.sp = st_reg.sp + SPW'(1);
            end
            // nesting disable lifts users to the top user level
            if (st_reg.nest_dis && st_reg.best_lvl <= USER_TOP_LEVEL) begin
                st_next.level = USER_TOP_LEVEL;
            end else begin
                st_next.level = st_reg.best_lvl;
            end
            st_next.acked_idx = st_reg.best_idx;
        end

        // aw and w taken in either order
        if (bus_req.awvalid && !st_reg.aw_held) begin
            st_next.aw_held = 1'b1;
            st_next.aw_addr = bus_req.awaddr;
        end
        if (bus_req.wvalid && !st_reg.w_held) begin
            st_next.w_held = 1'b1;
            st_next.w_data = bus_req.wdata;
            st_next.w_strb = bus_req.wstrb;
        end
        if (st_reg.bvalid && bus_req.bready) begin
            st_next.bvalid = 1'b0;
        end

        // register writes once both halves are held
        if (do_write) begin
            st_next.aw_held = 1'b0;
            st_next.w_held = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = known_addr(st_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            unique case (st_reg.aw_addr)
                OFF_CTU_PRIO: begin
                    wr_val = merge16({9'h000, st_reg.prio[0], 4'h0}, st_reg.w_data,
                                     st_reg.w_strb);
                    st_next.prio[0] = wr_val[CTU_PRIO_LSB +: 3];
                end
                OFF_CTRL_STAT: begin
                    wr_val = merge16({2'h0, st_reg.hold, 13'h0000}, st_reg.w_data,
                                     st_reg.w_strb);
                    st_next.hold = wr_val[HOLD_BIT];
                end
                OFF_CTRL_ONE: begin
                    wr_val = merge16({st_reg.nest_dis, 15'(st_reg.traps)}, st_reg.w_data,
                                     st_reg.w_strb);
                    st_next.nest_dis = wr_val[NEST_BIT];
                    st_next.traps = wr_val[N_TRAP-1:0];
                end
                OFF_FLAGS: begin
                    wr_val = merge16(16'(st_reg.flags), st_reg.w_data, st_reg.w_strb);
                    st_next.flags = wr_val[N_SRC-1:0];
                end
                OFF_ENABLES: begin
                    wr_val = merge16(16'(st_reg.enables), st_reg.w_data, st_reg.w_strb);
                    st_next.enables = wr_val[N_SRC-1:0];
                end
                OFF_STATUS_LOW: begin
                    // a trap level is left untouched
                    wr_val = merge16({8'h00, st_reg.level[2:0], 5'h00}, st_reg.w_data,
                                     st_reg.w_strb);
                    if (st_next.level <= USER_TOP_LEVEL) begin
                        st_next.level = {1'b0, wr_val[SRL_LEVEL_LSB +: 3]};
                    end
                end
                OFF_TIMED_DIS: begin
                    st_next.dis_count = merge16(st_reg.dis_count, st_reg.w_data,
                                                st_reg.w_strb);
                end
                default: begin
                    for (int i = 0; i < N_SRC; i++) begin
                        if (st_reg.aw_addr == OFF_PRIO_BASE + 32'(4 * i)) begin
                            wr_val = merge16({13'h0000, st_reg.prio[i]}, st_reg.w_data,
                                             st_reg.w_strb);
                            st_next.prio[i] = wr_val[2:0];
                        end
                    end
                end
            endcase
        end

        // hardware events win over a clearing write in the same cycle
        st_next.flags = st_next.flags | src_event;
        st_next.traps = st_next.traps | trap_event;

        // reads answer one cycle after ar
        if (st_reg.rvalid && bus_req.rready) begin
            st_next.rvalid = 1'b0;
        end
        if (bus_req.arvalid && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = known_addr(bus_req.araddr) ? RESP_OKAY : RESP_SLVERR;
            st_next.rdata = 32'h0000_0000;
            unique case (bus_req.araddr)
                OFF_CTU_PRIO: begin
                    st_next.rdata[CTU_PRIO_LSB +: 3] = st_reg.prio[0];
                end
                OFF_CTRL_STAT: begin
                    st_next.rdata[UNACK_BIT] = st_reg.unacked;
                    st_next.rdata[HOLD_BIT] = st_reg.hold;
                    st_next.rdata[LEVEL_LSB +: 4] = st_reg.level;
                    st_next.rdata[6:0] = st_reg.hold ? st_reg.best_idx
                                                     : st_reg.acked_idx;
                end
                OFF_CTRL_ONE: begin
                    st_next.rdata[NEST_BIT] = st_reg.nest_dis;
                    st_next.rdata[N_TRAP-1:0] = st_reg.traps;
                end
                OFF_FLAGS: begin
                    st_next.rdata[N_SRC-1:0] = st_reg.flags;
                end
                OFF_ENABLES: begin
                    st_next.rdata[N_SRC-1:0] = st_reg.enables;
                end
                OFF_STATUS_LOW: begin
                    st_next.rdata[SRL_LEVEL_LSB +: 3] = st_reg.level[2:0];
                    st_next.rdata[SRL_LEVEL3_BIT] = st_reg.level[3];
                end
                OFF_TIMED_DIS: begin
                    st_next.rdata[15:0] = st_reg.dis_count;
                end
                default: begin
                    for (int i = 0; i < N_SRC; i++) begin
                        if (bus_req.araddr == OFF_PRIO_BASE + 32'(4 * i)) begin
                            st_next.rdata[2:0] = st_reg.prio[i];
                        end
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
            for (int i = 0; i < N_SRC; i++) begin
                st_reg.prio[i] <= PRIO_RESET;
            end
            st_reg.level <= LEVEL_RESET;
            st_reg.dis_count <= DIS_COUNT_RESET;
            st_reg.bresp <= RESP_OKAY;
            st_reg.rresp <= RESP_OKAY;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

// ### shared/ipv_pkg.sv
// Purpose: constants and bus carriers of the interrupt block
// Assumes: AXI4-Lite, 16-bit registers in the low lanes
// Notes: offsets are byte addresses
package ipv_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [31:0] OFF_CTU_PRIO = 32'h0000_0000;
    localparam logic [31:0] OFF_CTRL_STAT = 32'h0000_0004;
    localparam logic [31:0] OFF_CTRL_ONE = 32'h0000_0008;
    localparam logic [31:0] OFF_FLAGS = 32'h0000_000c;
    localparam logic [31:0] OFF_ENABLES = 32'h0000_0010;
    localparam logic [31:0] OFF_STATUS_LOW = 32'h0000_0014;
    localparam logic [31:0] OFF_TIMED_DIS = 32'h0000_0018;
    localparam logic [31:0] OFF_PRIO_BASE = 32'h0000_0040;

    // ==========================================================
    // field positions
    localparam int CTU_PRIO_LSB = 4;
    localparam int UNACK_BIT = 15;
    localparam int HOLD_BIT = 13;
    localparam int LEVEL_LSB = 8;
    localparam int NEST_BIT = 15;
    localparam int SRL_LEVEL_LSB = 5;
    localparam int SRL_LEVEL3_BIT = 3;

    // ==========================================================
    // reset values and limits
    localparam logic [2:0] PRIO_RESET = 3'h4;
    localparam logic [2:0] PRIO_OFF = 3'h0;
    localparam logic [2:0] TIMED_MAX_PRIO = 3'h6;
    localparam logic [3:0] USER_TOP_LEVEL = 4'h7;
    localparam logic [3:0] TRAP_TOP_LEVEL = 4'hf;
    localparam logic [3:0] LEVEL_RESET = 4'h0;
    localparam logic [15:0] DIS_COUNT_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // AXI4-Lite carriers
    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } ipv_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ipv_axil_rsp_t;

endpackage

// ### hdl/ipv_arbiter.sv
// Purpose: pick the highest-level request, lowest index on a tie
// Assumes: combinational; level zero never wins
// Notes: index is the vector field, vector number minus eight
`timescale 1ns/1ns
module ipv_arbiter
    import ipv_pkg::*;
#(
    parameter int TOT = 12
) (
    input wire logic [TOT-1:0] req,
    input wire logic [TOT-1:0][3:0] levels,
    output logic valid,
    output logic [6:0] index,
    output logic [3:0] level
);

    // ==========================================================
    // elaboration checks
    if (TOT < 1 || TOT > 128) begin : g_bad_tot
        $error("bad arbiter width");
    end

    // ==========================================================
    // scan upward; strict compare keeps the lowest index on ties
    always_comb begin
        valid = 1'b0;
        index = 7'h00;
        level = 4'h0;
        for (int i = 0; i < TOT; i++) begin
            if (req[i] && levels[i] != 4'h0 && (!valid || levels[i] > level)) begin
                valid = 1'b1;
                index = 7'(i);
                level = levels[i];
            end
        end
    end

endmodule

// ### verification/ipv_irq_ctrl_chk.sv
// Purpose: port-level assertions of the interrupt block
// Assumes: synchronous active-high reset
// Notes: the write answer check expects aw and w to be offered together
`timescale 1ns/1ns
module ipv_irq_ctrl_chk
    import ipv_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire ipv_axil_req_t bus_req,
    input wire ipv_axil_rsp_t bus_rsp,
    input wire logic irq_ack,
    input wire logic irq_return,
    input wire logic irq_req,
    input wire logic [6:0] irq_vector_index,
    input wire logic [3:0] irq_level,
    input wire logic [3:0] cpu_level
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ==========================================================
    // write and ack steps
    sequence wr_taken;
        bus_req.awvalid && bus_rsp.awready && bus_req.wvalid && bus_rsp.wready;
    endsequence
    sequence ack_taken;
        irq_ack && irq_req && !irq_return;
    endsequence

    // ==========================================================
    // core side
    chk_reset_state: assert property ($fell(rst) |-> !irq_req && cpu_level == LEVEL_RESET
        && irq_vector_index == 7'h00) else $error("bad reset state");
    chk_req_above_level: assert property (irq_req |-> irq_level > cpu_level)
        else $error("request not above level");
    chk_ack_raise: assert property (ack_taken |=> cpu_level == $past(irq_level)
        || cpu_level == USER_TOP_LEVEL) else $error("bad ack level");
    chk_return_pop: assert property (irq_return && !irq_ack |=> cpu_level <= $past(cpu_level))
        else $error("return raised the level");

    // ==========================================================
    // register bus and request offer
    chk_bresp_hold: assert property (bus_rsp.bvalid && !bus_req.bready |=> bus_rsp.bvalid
        && $stable(bus_rsp.bresp)) else $error("bvalid dropped");
    chk_rdata_hold: assert property (bus_rsp.rvalid && !bus_req.rready |=> bus_rsp.rvalid
        && $stable(bus_rsp.rdata)) else $error("rvalid dropped");
    chk_offer_above: assert property (irq_level > cpu_level |-> irq_req)
        else $error("request not offered");
    chk_write_answer: assert property (wr_taken |-> ##2 bus_rsp.bvalid)
        else $error("write answer late");
    chk_read_answer: assert property (bus_req.arvalid && bus_rsp.arready |=> bus_rsp.rvalid)
        else $error("read answer late");
endmodule

bind ipv_irq_ctrl ipv_irq_ctrl_chk u_chk (.clk(clk), .rst(rst), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .irq_ack(irq_ack), .irq_return(irq_return), .irq_req(irq_req),
    .irq_vector_index(irq_vector_index), .irq_level(irq_level), .cpu_level(cpu_level));

// ### verification/ipv_core_model.sv
// Purpose: behavioural core that acks and returns
// Assumes: acks and returns only when told to
// Notes: acks a request that stood three cycles
`timescale 1ns/1ns
module ipv_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic irq_req,
    input wire logic auto_ack,
    input wire logic do_return,
    output logic irq_ack,
    output logic irq_return
);
    logic [1:0] wait_reg;

    // ==========================================================
    // one-cycle ack and return pulses
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
            wait_reg <= 2'h0;
        end else begin
            irq_return <= do_return;
            if (irq_ack || !irq_req || !auto_ack) begin
                irq_ack <= 1'b0; // never two acks for one request
                wait_reg <= 2'h0;
            end else if (wait_reg == 2'h2) begin
                irq_ack <= 1'b1;
            end else begin
                wait_reg <= wait_reg + 2'h1;
            end
        end
    end
endmodule

// ### verification/ipv_irq_ctrl_bench.sv
// Purpose: self-checking bench of the interrupt block
// Assumes: default parameters; user i has index 4+i
// Notes: handshakes are sampled at the settled falling edge
`timescale 1ns/1ns
module ipv_irq_ctrl_bench
    import ipv_pkg::*;
();
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] rexp;
        logic [1:0] resp;
    } ipv_row_t;
    logic clk;
    logic rst;
    ipv_axil_req_t req;
    ipv_axil_rsp_t rsp;
    logic [7:0] src_ev;
    logic [3:0] trap_ev;
    logic irq_ack, irq_return, irq_req, auto_ack, do_return;
    logic [6:0] vec_idx;
    logic [3:0] irq_lvl, cpu_lvl;
    logic [31:0] rd;
    logic [1:0] resp;
    int errors;
    int comparisons;
    ipv_row_t rows [5] = '{
        '{OFF_CTU_PRIO, 32'hffff, 32'h70, RESP_OKAY},
        '{OFF_PRIO_BASE + 32'hc, 32'h7, 32'h7, RESP_OKAY},
        '{OFF_PRIO_BASE + 32'h8, 32'h0, 32'h0, RESP_OKAY},
        '{32'h30, 32'h1234, 32'h0, RESP_SLVERR},
        '{32'h6, 32'h1234, 32'h0, RESP_SLVERR}
    };

    ipv_irq_ctrl dut (.clk(clk), .rst(rst), .bus_req(req), .bus_rsp(rsp), .src_event(src_ev),
        .trap_event(trap_ev), .irq_ack(irq_ack), .irq_return(irq_return), .irq_req(irq_req),
        .irq_vector_index(vec_idx), .irq_level(irq_lvl), .cpu_level(cpu_lvl));
    ipv_core_model core (.clk(clk), .rst(rst), .irq_req(irq_req), .auto_ack(auto_ack),
        .do_return(do_return), .irq_ack(irq_ack), .irq_return(irq_return));

    // ==========================================================
    // clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ==========================================================
    // verdict, compare and bounded waits
    task automatic complete_run();
        if (errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_up(input string what);
        errors++;
        $display("BAD %s expected done seen timeout", what);
        complete_run();
    endtask
    task automatic wait_req(input logic v, input int lim);
        int n;
        @(negedge clk);
        for (n = 0; n < lim && irq_req !== v; n++) @(negedge clk);
        if (irq_req !== v) give_up("irq_req");
    endtask
    // one-cycle event and return pulses
    task automatic drive(input logic [7:0] s, input logic [3:0] t, input logic r);
        @(posedge clk);
        src_ev <= s;
        trap_ev <= t;
        do_return <= r;
        @(posedge clk);
        src_ev <= 8'h00;
        trap_ev <= 4'h0;
        do_return <= 1'b0;
    endtask
    task automatic take();
        @(posedge clk);
        auto_ack <= 1'b1;
        wait_req(1'b0, 20);
        @(posedge clk);
        auto_ack <= 1'b0;
    endtask

    // ==========================================================
    // bus tasks; late ready makes the answer stand
    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        logic aw_ok, w_ok, b_ok;
        int n;
        b_ok = 1'b0;
        @(posedge clk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        for (n = 0; n < 40 && !b_ok; n++) begin
            @(negedge clk);
            aw_ok = req.awvalid && rsp.awready;
            w_ok = req.wvalid && rsp.wready;
            b_ok = rsp.bvalid && req.bready;
            resp = rsp.bresp;
            @(posedge clk);
            if (aw_ok) req.awvalid <= 1'b0;
            if (w_ok) req.wvalid <= 1'b0;
            if (n > 1) req.bready <= !b_ok;
        end
        if (!b_ok) give_up("bvalid");
    endtask
    task automatic bus_rd(input logic [31:0] a);
        logic ar_ok, r_ok;
        int n;
        r_ok = 1'b0;
        @(posedge clk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        for (n = 0; n < 40 && !r_ok; n++) begin
            @(negedge clk);
            ar_ok = req.arvalid && rsp.arready;
            r_ok = rsp.rvalid && req.rready;
            rd = rsp.rdata;
            resp = rsp.rresp;
            @(posedge clk);
            if (ar_ok) req.arvalid <= 1'b0;
            if (n > 0) req.rready <= !r_ok;
        end
        if (!r_ok) give_up("rvalid");
    endtask

    // ==========================================================
    // main sequence
    initial begin
        errors = 0;
        comparisons = 0;
        rst = 1'b1;
        req = '0;
        src_ev = 8'h00;
        trap_ev = 4'h0;
        auto_ack = 1'b0;
        do_return = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            bus_rd(OFF_PRIO_BASE + 32'(i * 4));
            check("prio reset", 32'(PRIO_RESET), rd);
        end
        bus_rd(OFF_CTU_PRIO);
        check("ctu prio reset", 32'h40, rd);
        for (int i = 0; i < 5; i++) begin
            bus_wr(rows[i].addr, rows[i].wdata);
            check("bresp", 32'(rows[i].resp), 32'(resp));
            bus_rd(rows[i].addr);
            check("rdata", rows[i].rexp, rd);
            check("rresp", 32'(rows[i].resp), 32'(resp));
        end
        // tie, ack, hold and return
        bus_wr(OFF_CTRL_ONE, 32'h0);
        bus_wr(OFF_PRIO_BASE + 32'h4, 32'h5);
        bus_wr(OFF_PRIO_BASE + 32'h8, 32'h5);
        bus_wr(OFF_FLAGS, 32'h0);
        bus_wr(OFF_ENABLES, 32'h6);
        drive(8'h06, 4'h0, 1'b0);
        wait_req(1'b1, 20);
        check("tie index", 32'h5, 32'(vec_idx));
        take();
        check("level after ack", 32'h5, 32'(cpu_lvl));
        bus_rd(OFF_CTRL_STAT);
        check("status taken", 32'h8505, rd);
        bus_wr(OFF_FLAGS, 32'h4);
        bus_wr(OFF_CTRL_STAT, 32'h2000);
        bus_rd(OFF_CTRL_STAT);
        check("status hold", 32'ha506, rd);
        bus_wr(OFF_CTRL_STAT, 32'h0);
        drive(8'h00, 4'h0, 1'b1);
        wait_req(1'b1, 20);
        check("return level", 32'h0, 32'(cpu_lvl));
        check("re-request index", 32'h6, 32'(vec_idx));
        bus_wr(OFF_FLAGS, 32'h0);
        wait_req(1'b0, 20);
        // mask users; traps pass and re-enter
        bus_wr(OFF_STATUS_LOW, 32'he0);
        check("masked level", 32'h7, 32'(cpu_lvl));
        drive(8'h02, 4'h0, 1'b0);
        repeat (4) @(negedge clk);
        check("user masked", 32'h0, 32'(irq_req));
        drive(8'h00, 4'h1, 1'b0);
        wait_req(1'b1, 20);
        check("trap level", 32'hf, 32'(irq_lvl));
        check("trap index", 32'h0, 32'(vec_idx));
        take();
        drive(8'h00, 4'h0, 1'b1);
        wait_req(1'b1, 20);
        check("trap again", 32'h0, 32'(vec_idx));
        take();
        bus_wr(OFF_CTRL_ONE, 32'h0);
        drive(8'h00, 4'h0, 1'b1);
        repeat (4) @(negedge clk);
        check("level restored", 32'h7, 32'(cpu_lvl));
        check("trap cleared", 32'h0, 32'(irq_req));
        bus_wr(OFF_STATUS_LOW, 32'h0);
        wait_req(1'b1, 20);
        check("unmasked index", 32'h5, 32'(vec_idx));
        // timed disable holds level 6 back, not level 7
        bus_wr(OFF_FLAGS, 32'h0);
        bus_wr(OFF_PRIO_BASE + 32'h4, 32'h6);
        bus_wr(OFF_ENABLES, 32'ha);
        bus_wr(OFF_TIMED_DIS, 32'hc8);
        drive(8'h02, 4'h0, 1'b0);
        repeat (4) @(negedge clk);
        check("level 6 blocked", 32'h0, 32'(irq_req));
        drive(8'h08, 4'h0, 1'b0);
        wait_req(1'b1, 20);
        check("level 7 passes", 32'h7, 32'(vec_idx));
        bus_wr(OFF_FLAGS, 32'h2);
        wait_req(1'b0, 20);
        wait_req(1'b1, 300);
        check("after count", 32'h5, 32'(vec_idx));
        // second reset in mid-run
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bus_rd(OFF_PRIO_BASE + 32'h4);
        check("prio reset 2", 32'(PRIO_RESET), rd);
        bus_rd(OFF_CTRL_STAT);
        check("status reset 2", 32'h0, rd);
        complete_run();
    end
endmodule
